//--- hw/qcic_params.svh
// Constants for the queue count and interrupt coalescing feature block
`ifndef QCIC_PARAMS_SVH
`define QCIC_PARAMS_SVH

// ----------------------------------------------------------------------
// Feature identifiers and completion status codes
// ----------------------------------------------------------------------
`define QCIC_FID_NUM_QUEUES 8'h07
`define QCIC_FID_COALESCE 8'h08
`define QCIC_SC_SUCCESS 8'h00
`define QCIC_SC_INVALID_FIELD 8'h02
`define QCIC_SC_CMD_SEQ_ERROR 8'h0c

// ----------------------------------------------------------------------
// Dword 11 and dword 0 field positions
// ----------------------------------------------------------------------
`define QCIC_CQ_FIELD 31:16
`define QCIC_SQ_FIELD 15:0
`define QCIC_RSVD_FIELD 31:16
`define QCIC_TIME_FIELD 15:8
`define QCIC_THRESH_FIELD 7:0
`define QCIC_CNT_INVALID 16'hffff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define QCIC_RST_TIME 8'h00
`define QCIC_RST_THRESH 8'h00
`define QCIC_RST_CQ_LIMIT 16'h003f
`define QCIC_RST_SQ_LIMIT 16'h003f
`define QCIC_RST_OPTIONS 2'h0

// ----------------------------------------------------------------------
// Register map and option bits
// ----------------------------------------------------------------------
`define QCIC_REG_LIMITS 8'h00
`define QCIC_REG_OPTIONS 8'h04
`define QCIC_REG_ALLOC 8'h08
`define QCIC_REG_COALESCE 8'h0c
`define QCIC_REG_STATUS 8'h10
`define QCIC_OPT_POW2_BIT 0
`define QCIC_OPT_DB_RESTART_BIT 1
`define QCIC_OPT_FIELD 1:0

// ----------------------------------------------------------------------
// Timing and interrupt vector count
// ----------------------------------------------------------------------
`define QCIC_TIME_UNIT_NS 100000
`define QCIC_CLK_PERIOD_NS 5
`define QCIC_NVEC 8

`endif

//--- hw/qcic_pkg.sv
// Types shared by the queue count and interrupt coalescing block
package qcic_pkg;
   typedef logic [15:0] qcic_qcnt_t;
   typedef logic [7:0] qcic_status_t;
   typedef logic [2:0] qcic_vec_t;
   typedef logic [7:0] qcic_addr_t;
   typedef logic [31:0] qcic_word_t;
endpackage

//--- hw/qcic_feature_core.sv
// Queue count negotiation and per-vector interrupt coalescing
`include "qcic_params.svh"

module qcic_feature_core #(
   parameter int TICK_CYCLES = `QCIC_TIME_UNIT_NS / `QCIC_CLK_PERIOD_NS
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_is_set_in,
   input wire logic [7:0] cmd_fid_in,
   input wire qcic_pkg::qcic_word_t cmd_dw11_in,
   input wire logic io_queue_exists_in,
   output logic rsp_valid_out,
   output qcic_pkg::qcic_word_t rsp_dw0_out,
   output qcic_pkg::qcic_status_t rsp_status_out,
   input wire logic cpl_valid_in,
   input wire qcic_pkg::qcic_vec_t cpl_vector_in,
   input wire logic cpl_admin_in,
   input wire logic cpl_error_in,
   input wire logic db_valid_in,
   input wire qcic_pkg::qcic_vec_t db_vector_in,
   input wire logic irq_mode_change_in,
   output logic [`QCIC_NVEC-1:0] irq_vec_out,
   input wire qcic_pkg::qcic_addr_t reg_addr_in,
   input wire qcic_pkg::qcic_word_t reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output qcic_pkg::qcic_word_t reg_rdata_out
);
   import qcic_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   qcic_qcnt_t cq_limit_r;
   qcic_qcnt_t sq_limit_r;
   logic [1:0] options_r;
   qcic_qcnt_t cq_count_allocated_r;
   qcic_qcnt_t sq_count_allocated_r;
   logic alloc_done_r;
   logic [7:0] agg_time_r;
   logic [7:0] aggregation_entry_threshold_r;
   logic [14:0] tick_cnt_r;
   logic tick;
   logic coal_off;
   logic [8:0] vcnt_r [`QCIC_NVEC];
   logic [7:0] velapsed_r [`QCIC_NVEC];
   logic [`QCIC_NVEC-1:0] fire;

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   qcic_qcnt_t cq_count_requested;
   qcic_qcnt_t sq_count_requested;
   qcic_qcnt_t cq_alloc_nxt;
   qcic_qcnt_t sq_alloc_nxt;
   logic set_nq;
   logic get_nq;
   logic set_coal;
   logic get_coal;
   logic nq_seq_err;
   logic nq_bad_field;

   function automatic qcic_qcnt_t qcic_round_pow2(input qcic_qcnt_t n);
      qcic_qcnt_t v;
      v = n;
      for (int s = 1; s < 16; s = s * 2)
      begin
         v = v | (v >> s);
      end
      return v;
   endfunction
   function automatic qcic_qcnt_t qcic_fit(input qcic_qcnt_t req, input qcic_qcnt_t lim, input logic pow2);
      qcic_qcnt_t r;
      r = pow2 ? qcic_round_pow2(req) : req;
      return (r > lim) ? lim : r;
   endfunction
   assign set_nq = cmd_valid_in && cmd_is_set_in && (cmd_fid_in == `QCIC_FID_NUM_QUEUES);
   assign get_nq = cmd_valid_in && !cmd_is_set_in && (cmd_fid_in == `QCIC_FID_NUM_QUEUES);
   assign set_coal = cmd_valid_in && cmd_is_set_in && (cmd_fid_in == `QCIC_FID_COALESCE);
   assign get_coal = cmd_valid_in && !cmd_is_set_in && (cmd_fid_in == `QCIC_FID_COALESCE);
   // Both fields are zero-based I/O queue counts only
   assign cq_count_requested = cmd_dw11_in[`QCIC_CQ_FIELD];
   assign sq_count_requested = cmd_dw11_in[`QCIC_SQ_FIELD];
   assign nq_seq_err = io_queue_exists_in;
   assign nq_bad_field = (cq_count_requested == `QCIC_CNT_INVALID) ||
                         (sq_count_requested == `QCIC_CNT_INVALID);
   // Grant may be rounded up to a power of two and is clamped to the pool
   assign cq_alloc_nxt = qcic_fit(cq_count_requested, cq_limit_r, options_r[`QCIC_OPT_POW2_BIT]);
   assign sq_alloc_nxt = qcic_fit(sq_count_requested, sq_limit_r, options_r[`QCIC_OPT_POW2_BIT]);

   // ----------------------------------------------------------------------
   // Queue count allocation
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         cq_count_allocated_r <= '0;
         sq_count_allocated_r <= '0;
         alloc_done_r <= 1'b0;
      end
      else if (set_nq && !nq_seq_err && !nq_bad_field && !alloc_done_r)
      begin
         // Only the first good set allocates; later ones see the same grant
         cq_count_allocated_r <= cq_alloc_nxt;
         sq_count_allocated_r <= sq_alloc_nxt;
         alloc_done_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Completion result
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         rsp_valid_out <= 1'b0;
         rsp_dw0_out <= '0;
         rsp_status_out <= `QCIC_SC_SUCCESS;
      end
      else
      begin
         rsp_valid_out <= cmd_valid_in;
         rsp_dw0_out <= '0;
         rsp_status_out <= `QCIC_SC_SUCCESS;
         if (set_nq && nq_seq_err)
         begin
            rsp_status_out <= `QCIC_SC_CMD_SEQ_ERROR;
         end
         else if (set_nq && nq_bad_field)
         begin
            rsp_status_out <= `QCIC_SC_INVALID_FIELD;
         end
         else if (set_nq && !alloc_done_r)
         begin
            rsp_dw0_out <= {cq_alloc_nxt, sq_alloc_nxt};
         end
         else if (set_nq || get_nq)
         begin
            // Get never looks at dword 11
            rsp_dw0_out <= {cq_count_allocated_r, sq_count_allocated_r};
         end
         else if (get_coal)
         begin
            rsp_dw0_out <= {16'h0000, agg_time_r, aggregation_entry_threshold_r};
         end
         else if (cmd_valid_in && !set_coal)
         begin
            rsp_status_out <= `QCIC_SC_INVALID_FIELD;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Coalescing settings
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         agg_time_r <= `QCIC_RST_TIME;
         aggregation_entry_threshold_r <= `QCIC_RST_THRESH;
      end
      else if (set_coal)
      begin
         // Upper half of dword 11 is dropped
         agg_time_r <= cmd_dw11_in[`QCIC_TIME_FIELD];
         aggregation_entry_threshold_r <= cmd_dw11_in[`QCIC_THRESH_FIELD];
      end
      else if (irq_mode_change_in)
      begin
         agg_time_r <= `QCIC_RST_TIME;
         aggregation_entry_threshold_r <= `QCIC_RST_THRESH;
      end
   end

   assign coal_off = (agg_time_r == `QCIC_RST_TIME) || (aggregation_entry_threshold_r == `QCIC_RST_THRESH);

   // ----------------------------------------------------------------------
   // Aggregation time base, one tick per time unit
   // ----------------------------------------------------------------------
   assign tick = (tick_cnt_r == 15'(TICK_CYCLES - 1));
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in || tick)
      begin
         tick_cnt_r <= '0;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 15'h0001;
      end
   end

   // ----------------------------------------------------------------------
   // Per-vector aggregation
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < `QCIC_NVEC; g++)
   begin : g_vec
      logic hit;
      logic flush_now;
      logic count_hit;
      logic time_hit;
      logic db_restart;
      assign hit = cpl_valid_in && (cpl_vector_in == qcic_vec_t'(g));
      // Admin, error and uncoalesced completions interrupt at once
      assign flush_now = hit && (cpl_admin_in || cpl_error_in || coal_off);
      // Entry makes vcnt+1 held; zero-based threshold wants threshold+1
      assign count_hit = hit && (vcnt_r[g] >= {1'b0, aggregation_entry_threshold_r});
      assign time_hit = (vcnt_r[g] != 9'h000) && tick &&
                        ({1'b0, velapsed_r[g]} + 9'h001 >= {1'b0, agg_time_r});
      assign db_restart = db_valid_in && (db_vector_in == qcic_vec_t'(g)) &&
                          options_r[`QCIC_OPT_DB_RESTART_BIT];
      // Held entries are released if coalescing is turned off under them
      assign fire[g] = flush_now || count_hit || time_hit || (coal_off && vcnt_r[g] != 9'h000);
      always_ff @(posedge clk_sys_in)
      begin
         if (!rst_n_in || fire[g])
         begin
            vcnt_r[g] <= '0;
         end
         else if (db_restart)
         begin
            vcnt_r[g] <= hit ? 9'h001 : 9'h000;
         end
         else if (hit)
         begin
            vcnt_r[g] <= vcnt_r[g] + 9'h001;
         end
      end

      always_ff @(posedge clk_sys_in)
      begin
         if (!rst_n_in || fire[g] || db_restart || vcnt_r[g] == 9'h000)
         begin
            velapsed_r[g] <= '0;
         end
         else if (tick && velapsed_r[g] != 8'hff)
         begin
            velapsed_r[g] <= velapsed_r[g] + 8'h01;
         end
      end

      always_ff @(posedge clk_sys_in)
      begin
         if (!rst_n_in)
         begin
            irq_vec_out[g] <= 1'b0;
         end
         else
         begin
            irq_vec_out[g] <= fire[g];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         cq_limit_r <= `QCIC_RST_CQ_LIMIT;
         sq_limit_r <= `QCIC_RST_SQ_LIMIT;
         options_r <= `QCIC_RST_OPTIONS;
      end
      else if (reg_wr_in && reg_addr_in == `QCIC_REG_LIMITS)
      begin
         cq_limit_r <= reg_wdata_in[`QCIC_CQ_FIELD];
         sq_limit_r <= reg_wdata_in[`QCIC_SQ_FIELD];
      end
      else if (reg_wr_in && reg_addr_in == `QCIC_REG_OPTIONS)
      begin
         options_r <= reg_wdata_in[`QCIC_OPT_FIELD];
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in || !reg_rd_in)
      begin
         reg_rdata_out <= '0;
      end
      else
      begin
         unique case (reg_addr_in)
            `QCIC_REG_LIMITS: reg_rdata_out <= {cq_limit_r, sq_limit_r};
            `QCIC_REG_OPTIONS: reg_rdata_out <= {30'h0, options_r};
            `QCIC_REG_ALLOC: reg_rdata_out <= {cq_count_allocated_r, sq_count_allocated_r};
            `QCIC_REG_COALESCE: reg_rdata_out <= {16'h0000, agg_time_r, aggregation_entry_threshold_r};
            `QCIC_REG_STATUS: reg_rdata_out <= {30'h0, io_queue_exists_in, alloc_done_r};
            default: reg_rdata_out <= '0;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence s_late_set;
      set_nq && io_queue_exists_in;
   endsequence
   sequence s_seq_err_rsp;
      rsp_valid_out && rsp_status_out == `QCIC_SC_CMD_SEQ_ERROR;
   endsequence
   chk_late_set_fails: assert property (s_late_set |=> s_seq_err_rsp)
      else $error("late queue count set not failed");
   chk_alloc_frozen: assert property (alloc_done_r |=> $stable(cq_count_allocated_r) && $stable(sq_count_allocated_r))
      else $error("allocated counts changed");
   chk_get_reports_alloc: assert property (get_nq |=>
      rsp_valid_out && rsp_dw0_out == {cq_count_allocated_r, sq_count_allocated_r})
      else $error("get queue count result wrong");
   chk_invalid_count: assert property (set_nq && !io_queue_exists_in && nq_bad_field |=>
      rsp_status_out == `QCIC_SC_INVALID_FIELD && !$changed(alloc_done_r))
      else $error("invalid queue count accepted");
   chk_grant_bounded: assert property (set_nq && !nq_seq_err && !nq_bad_field && !alloc_done_r |=>
      alloc_done_r && cq_count_allocated_r <= $past(cq_limit_r) && rsp_dw0_out[`QCIC_SQ_FIELD] == sq_count_allocated_r)
      else $error("grant not within pool");
   chk_admin_direct: assert property (cpl_valid_in && cpl_admin_in |=> irq_vec_out[$past(cpl_vector_in)])
      else $error("admin completion coalesced");
   chk_error_direct: assert property (cpl_valid_in && cpl_error_in |=> irq_vec_out[$past(cpl_vector_in)])
      else $error("error completion coalesced");
   chk_off_direct: assert property (cpl_valid_in && coal_off |=> irq_vec_out[$past(cpl_vector_in)])
      else $error("completion held while coalescing off");
   chk_threshold_fire: assert property (cpl_valid_in && cpl_vector_in == 3'h0 && !coal_off &&
      vcnt_r[0] >= {1'b0, aggregation_entry_threshold_r} |=> irq_vec_out[0] ##1 vcnt_r[0] <= 9'h001)
      else $error("threshold reached without interrupt");
   chk_coal_get: assert property (get_coal |=>
      rsp_dw0_out == {16'h0000, $past(agg_time_r), $past(aggregation_entry_threshold_r)})
      else $error("coalescing get result wrong");
   chk_mode_drop: assert property (irq_mode_change_in && !set_coal |=>
      agg_time_r == `QCIC_RST_TIME && aggregation_entry_threshold_r == `QCIC_RST_THRESH)
      else $error("settings kept over mode change");
endmodule

//--- verif/qcic_host_model.sv
// Host-side model that issues feature commands and creates I/O queues
module qcic_host_model (
   input wire logic clk_sys_in,
   output logic cmd_valid_out,
   output logic cmd_is_set_out,
   output logic [7:0] cmd_fid_out,
   output qcic_pkg::qcic_word_t cmd_dw11_out,
   output logic io_queue_exists_out,
   input wire logic rsp_valid_in,
   input wire qcic_pkg::qcic_word_t rsp_dw0_in,
   input wire qcic_pkg::qcic_status_t rsp_status_in
);
   timeunit 1ns;
   timeprecision 100ps;
   import qcic_pkg::*;

   initial
   begin
      cmd_valid_out = 1'b0;
      cmd_is_set_out = 1'b0;
      cmd_fid_out = 8'h00;
      cmd_dw11_out = 32'h0;
      io_queue_exists_out = 1'b0;
   end

   // ---------------------------------------------------------------
   // One feature command, answer taken in the cycle after the request
   // ---------------------------------------------------------------
   // Count fields are sent as given; ffff goes to refusal tests and to one get
   task automatic feature(input logic set, input logic [7:0] fid, input qcic_word_t dw11,
                          output qcic_word_t dw0, output qcic_status_t st, output logic vld);
      @(posedge clk_sys_in);
      cmd_valid_out <= 1'b1;
      cmd_is_set_out <= set;
      cmd_fid_out <= fid;
      cmd_dw11_out <= dw11;
      @(posedge clk_sys_in);
      cmd_valid_out <= 1'b0;
      cmd_fid_out <= ~fid;
      cmd_dw11_out <= ~dw11;
      #1;
      vld = rsp_valid_in;
      dw0 = rsp_dw0_in;
      st = rsp_status_in;
   endtask

   // Queues are created only after the queue count was negotiated
   task automatic create_queues;
      @(posedge clk_sys_in);
      io_queue_exists_out <= 1'b1;
   endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the queue count and interrupt coalescing block
`include "qcic_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import qcic_pkg::*;

   localparam logic [7:0] FQ = `QCIC_FID_NUM_QUEUES;
   localparam logic [7:0] FC = `QCIC_FID_COALESCE;
   localparam qcic_status_t OK = `QCIC_SC_SUCCESS;
   localparam qcic_status_t BAD = `QCIC_SC_INVALID_FIELD;
   localparam qcic_status_t SEQ = `QCIC_SC_CMD_SEQ_ERROR;

   logic clk_sys_in, rst_n_in, cmd_valid, cmd_is_set, io_q, rsp_valid;
   logic [7:0] cmd_fid;
   qcic_word_t cmd_dw11, rsp_dw0, reg_wdata, reg_rdata;
   qcic_status_t rsp_status;
   logic cpl_valid, cpl_admin, cpl_error, db_valid, mode_chg, reg_wr, reg_rd;
   qcic_vec_t cpl_vector, db_vector;
   logic [7:0] irq_vec;
   qcic_addr_t reg_addr;
   int num_errors = 0;
   int comparisons = 0;
   int n;

   qcic_host_model host (.clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid), .cmd_is_set_out(cmd_is_set),
      .cmd_fid_out(cmd_fid), .cmd_dw11_out(cmd_dw11), .io_queue_exists_out(io_q), .rsp_valid_in(rsp_valid),
      .rsp_dw0_in(rsp_dw0), .rsp_status_in(rsp_status));

   qcic_feature_core #(.TICK_CYCLES(4)) uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .cmd_valid_in(cmd_valid), .cmd_is_set_in(cmd_is_set), .cmd_fid_in(cmd_fid), .cmd_dw11_in(cmd_dw11),
      .io_queue_exists_in(io_q), .rsp_valid_out(rsp_valid), .rsp_dw0_out(rsp_dw0), .rsp_status_out(rsp_status),
      .cpl_valid_in(cpl_valid), .cpl_vector_in(cpl_vector), .cpl_admin_in(cpl_admin), .cpl_error_in(cpl_error),
      .db_valid_in(db_valid), .db_vector_in(db_vector), .irq_mode_change_in(mode_chg), .irq_vec_out(irq_vec),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Dword 0 is not judged on a sequence error, where it is left open
   task automatic feat(input logic set, input logic [7:0] fid, input qcic_word_t dw11, input qcic_word_t exp_dw0,
                       input qcic_status_t exp_st);
      qcic_word_t dw0;
      qcic_status_t st;
      logic vld;
      host.feature(set, fid, dw11, dw0, st, vld);
      check({31'h0, vld}, 32'h1);
      check({24'h0, st}, {24'h0, exp_st});
      if (exp_st !== SEQ)
         check(dw0, exp_dw0);
   endtask

   task automatic reg_wr_t(input qcic_addr_t a, input qcic_word_t d);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_rd_t(input qcic_addr_t a, input qcic_word_t exp);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask

   task automatic cpl(input qcic_vec_t v, input logic adm, input logic err, input logic [7:0] exp_irq);
      @(posedge clk_sys_in);
      cpl_valid <= 1'b1;
      cpl_vector <= v;
      cpl_admin <= adm;
      cpl_error <= err;
      @(posedge clk_sys_in);
      cpl_valid <= 1'b0;
      #1;
      check({24'h0, irq_vec}, {24'h0, exp_irq});
   endtask

   task automatic pulse(input logic is_db, input qcic_vec_t v);
      @(posedge clk_sys_in);
      db_valid <= is_db;
      mode_chg <= ~is_db;
      db_vector <= v;
      @(posedge clk_sys_in);
      db_valid <= 1'b0;
      mode_chg <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial
   begin
      {rst_n_in, cpl_valid, cpl_admin, cpl_error, db_valid, mode_chg, reg_wr, reg_rd} = 8'h00;
      {cpl_vector, db_vector, reg_addr, reg_wdata} = 46'h0;
      repeat (2) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      feat(1'b0, FQ, 32'h1234_5678, 32'h0, OK);
      feat(1'b0, FC, 32'h0, 32'h0, OK);
      reg_rd_t(`QCIC_REG_LIMITS, 32'h003f_003f);
      reg_wr_t(`QCIC_REG_ALLOC, 32'h5a5a_5a5a);
      reg_rd_t(`QCIC_REG_ALLOC, 32'h0);
      reg_rd_t(8'h40, 32'h0);
      $display("Test reset values done");
      feat(1'b1, FQ, 32'hffff_0001, 32'h0, BAD);
      feat(1'b1, FQ, 32'h0001_ffff, 32'h0, BAD);
      feat(1'b1, 8'h05, 32'h0, 32'h0, BAD);
      $display("Test refusals done");
      reg_wr_t(`QCIC_REG_LIMITS, 32'h0004_003f);
      reg_wr_t(`QCIC_REG_OPTIONS, 32'h1);
      feat(1'b1, FQ, 32'h0005_0009, 32'h0004_000f, OK);
      feat(1'b0, FQ, 32'hffff_ffff, 32'h0004_000f, OK);
      feat(1'b1, FQ, 32'h0001_0001, 32'h0004_000f, OK);
      reg_rd_t(`QCIC_REG_ALLOC, 32'h0004_000f);
      host.create_queues();
      feat(1'b1, FQ, 32'hffff_ffff, 32'h0, SEQ);
      feat(1'b0, FQ, 32'h0, 32'h0004_000f, OK);
      reg_rd_t(`QCIC_REG_STATUS, 32'h3);
      $display("Test queue count done");
      cpl(3'h1, 1'b0, 1'b0, 8'h02);
      feat(1'b1, FC, 32'hffff_0201, 32'h0, OK);
      feat(1'b0, FC, 32'h0, 32'h0000_0201, OK);
      reg_rd_t(`QCIC_REG_COALESCE, 32'h0000_0201);
      cpl(3'h0, 1'b0, 1'b0, 8'h00);
      cpl(3'h0, 1'b0, 1'b0, 8'h01);
      cpl(3'h2, 1'b1, 1'b0, 8'h04);
      cpl(3'h3, 1'b0, 1'b1, 8'h08);
      cpl(3'h4, 1'b0, 1'b0, 8'h00);
      n = 0;
      while (irq_vec[4] !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      check({31'h0, n >= 5 && n <= 9}, 32'h1);
      $display("Test coalescing done");
      reg_wr_t(`QCIC_REG_OPTIONS, 32'h2);
      cpl(3'h5, 1'b0, 1'b0, 8'h00);
      pulse(1'b1, 3'h5);
      cpl(3'h5, 1'b0, 1'b0, 8'h00);
      cpl(3'h5, 1'b0, 1'b0, 8'h20);
      pulse(1'b0, 3'h0);
      feat(1'b0, FC, 32'h0, 32'h0, OK);
      cpl(3'h6, 1'b0, 1'b0, 8'h40);
      $display("Test doorbell and mode change done");
      final_report();
   end

   initial
   begin
      #20000;
      num_errors++;
      final_report();
   end
endmodule
